// ==== core/nacd_cmd_decode.sv ====
`timescale 1ns/1ps
// Behaviour
// - 5B takes start, end address, then check
// - plain read 03 variable, 13 four-byte address
// - fast read 0B variable, 0C address plus mode
// - program 02 variable address, needs write enable
// - program 12 four-byte address, needs write enable
// - small erase 20 variable address, needs enable
// - small erase 21 four-byte address, needs enable
// - large erase D8 variable address, needs enable
// - B7 selects four-byte, B8 three-byte addresses
module nacd_cmd_decode #(
   parameter int PAGE_BYTES = nacd_pkg::PAGE_BYTES_DEFAULT,
   parameter logic [7:0] WREN_OPCODE = 8'h06
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SI,
   output logic SO,
   output logic SO_OE_N,
   output logic [31:0] ARRAY_ADDR,
   output logic RD_STB,
   input wire logic [7:0] RD_DATA,
   output logic PGM_STB,
   output logic [7:0] PGM_DATA,
   output logic PGM_COMMIT,
   output logic ERASE_STB,
   output logic ERASE_LARGE,
   output logic CHECK_STB,
   output logic [31:0] CHECK_END_ADDR,
   output logic WIDE_ADDR,
   output logic WRITE_EN_LATCH
);

   localparam int PW = $clog2(PAGE_BYTES);

   logic sck_rise, sck_fall, cs_act, cs_end, si_s;
   nacd_pkg::nacd_state_t state;
   logic [2:0] bit_cnt;
   logic [6:0] sh_in;
   logic [7:0] rx_byte;
   logic byte_evt;
   logic [7:0] cmd;
   logic cmd_ok;
   logic bare;
   logic addr_done;
   logic [3:0] need;
   logic [3:0] byte_cnt;
   logic [63:0] addr_sh;
   logic [PW-1:0] pg_cnt;
   logic pg_any;
   logic [7:0] pf;
   logic rd_pend;
   logic [7:0] out_sh;
   logic [2:0] out_cnt;
   logic [7:0] out_next;
   logic [3:0] op_need;
   logic op_wel;
   logic [PW-1:0] pg_off;

   // ---------------------------------------------------------------
   // link sampling
   // ---------------------------------------------------------------
   nacd_link_sync u_sync (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .sck(SCK),
      .cs_n(CS_N),
      .si(SI),
      .sck_rise(sck_rise),
      .sck_fall(sck_fall),
      .cs_act(cs_act),
      .cs_end(cs_end),
      .si_s(si_s)
   );

   // ---------------------------------------------------------------
   // opcode decode
   // ---------------------------------------------------------------
   assign rx_byte = {sh_in, si_s};
   assign byte_evt = cs_act & sck_rise & (bit_cnt == nacd_pkg::BIT_LAST);
   assign pg_off = addr_sh[PW-1:0] + pg_cnt;

   // address length per opcode; zero means no address follows
   always_comb begin
      op_need = 4'h0;
      op_wel = 1'b0;
      unique case (rx_byte)
         nacd_pkg::OP_RANGE_CHECK: op_need = nacd_pkg::RANGE_ADDR_BYTES;
         nacd_pkg::OP_PLAIN_READ_4B,
         nacd_pkg::OP_FAST_READ_4B: op_need = nacd_pkg::WIDE_ADDR_BYTES;
         nacd_pkg::OP_PLAIN_READ_VAR,
         nacd_pkg::OP_FAST_READ_VAR: begin
            op_need = WIDE_ADDR ? nacd_pkg::WIDE_ADDR_BYTES : nacd_pkg::NARROW_ADDR_BYTES;
         end
         nacd_pkg::OP_PROGRAM_4B,
         nacd_pkg::OP_SMALL_ERASE_4B: begin
            op_need = nacd_pkg::WIDE_ADDR_BYTES;
            op_wel = 1'b1;
         end
         nacd_pkg::OP_PROGRAM_VAR,
         nacd_pkg::OP_SMALL_ERASE_VAR,
         nacd_pkg::OP_LARGE_ERASE_VAR: begin
            op_need = WIDE_ADDR ? nacd_pkg::WIDE_ADDR_BYTES : nacd_pkg::NARROW_ADDR_BYTES;
            op_wel = 1'b1;
         end
         default: op_need = 4'h0;
      endcase
   end

   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   // a deselect ends every frame; erase, check and program commit are only issued there
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= nacd_pkg::NACD_ST_CMD;
         bit_cnt <= 3'h0;
         sh_in <= 7'h00;
         cmd <= 8'h00;
         cmd_ok <= 1'b0;
         bare <= 1'b0;
         addr_done <= 1'b0;
         need <= 4'h0;
         byte_cnt <= 4'h0;
         addr_sh <= 64'h0;
         pg_cnt <= '0;
         pg_any <= 1'b0;
         ARRAY_ADDR <= 32'h0;
         CHECK_END_ADDR <= 32'h0;
         RD_STB <= 1'b0;
         PGM_STB <= 1'b0;
         PGM_DATA <= 8'h00;
         PGM_COMMIT <= 1'b0;
         ERASE_STB <= 1'b0;
         ERASE_LARGE <= 1'b0;
         CHECK_STB <= 1'b0;
      end else begin
         RD_STB <= 1'b0;
         PGM_STB <= 1'b0;
         PGM_COMMIT <= 1'b0;
         ERASE_STB <= 1'b0;
         CHECK_STB <= 1'b0;
         if (!cs_act) begin
            if (cs_end && cmd_ok && addr_done) begin
               unique case (cmd)
                  nacd_pkg::OP_RANGE_CHECK: begin
                     CHECK_STB <= 1'b1;
                     ARRAY_ADDR <= addr_sh[63:32];
                     CHECK_END_ADDR <= addr_sh[31:0];
                  end
                  nacd_pkg::OP_SMALL_ERASE_VAR,
                  nacd_pkg::OP_SMALL_ERASE_4B: begin
                     ERASE_STB <= 1'b1;
                     ERASE_LARGE <= 1'b0;
                     ARRAY_ADDR <= addr_sh[31:0];
                  end
                  nacd_pkg::OP_LARGE_ERASE_VAR: begin
                     ERASE_STB <= 1'b1;
                     ERASE_LARGE <= 1'b1;
                     ARRAY_ADDR <= addr_sh[31:0];
                  end
                  default: PGM_COMMIT <= pg_any;
               endcase
            end
            state <= nacd_pkg::NACD_ST_CMD;
            bit_cnt <= 3'h0;
            byte_cnt <= 4'h0;
            addr_sh <= 64'h0;
            pg_cnt <= '0;
            pg_any <= 1'b0;
            addr_done <= 1'b0;
            cmd_ok <= 1'b0;
            bare <= 1'b0;
         end else begin
            if (sck_rise) begin
               bit_cnt <= bit_cnt + 3'h1;
               sh_in <= rx_byte[6:0];
               bare <= 1'b0;
            end
            if (byte_evt) begin
               unique case (state)
                  nacd_pkg::NACD_ST_CMD: begin
                     cmd <= rx_byte;
                     need <= op_need;
                     bare <= (op_need == 4'h0);
                     // without write enable the frame is swallowed
                     cmd_ok <= ~op_wel | WRITE_EN_LATCH;
                     if (op_need == 4'h0 || (op_wel && !WRITE_EN_LATCH)) begin
                        state <= nacd_pkg::NACD_ST_HOLD;
                     end else begin
                        state <= nacd_pkg::NACD_ST_ADDR;
                     end
                  end
                  nacd_pkg::NACD_ST_ADDR: begin
                     addr_sh <= {addr_sh[55:0], rx_byte};
                     byte_cnt <= byte_cnt + 4'h1;
                     if (byte_cnt + 4'h1 == need) begin
                        addr_done <= 1'b1;
                        unique case (cmd)
                           nacd_pkg::OP_PLAIN_READ_VAR,
                           nacd_pkg::OP_PLAIN_READ_4B: begin
                              state <= nacd_pkg::NACD_ST_RDOUT;
                              RD_STB <= 1'b1;
                              ARRAY_ADDR <= {addr_sh[23:0], rx_byte};
                           end
                           nacd_pkg::OP_FAST_READ_VAR,
                           nacd_pkg::OP_FAST_READ_4B: begin
                              state <= nacd_pkg::NACD_ST_DUMMY;
                           end
                           nacd_pkg::OP_PROGRAM_VAR,
                           nacd_pkg::OP_PROGRAM_4B: state <= nacd_pkg::NACD_ST_PGIN;
                           default: state <= nacd_pkg::NACD_ST_HOLD;
                        endcase
                     end
                  end
                  nacd_pkg::NACD_ST_DUMMY: begin
                     // one mode or wait byte, then data starts
                     state <= nacd_pkg::NACD_ST_RDOUT;
                     RD_STB <= 1'b1;
                     ARRAY_ADDR <= addr_sh[31:0];
                  end
                  nacd_pkg::NACD_ST_PGIN: begin
                     // offset wraps inside the page, base stays put
                     PGM_STB <= 1'b1;
                     PGM_DATA <= rx_byte;
                     ARRAY_ADDR <= {addr_sh[31:PW], pg_off};
                     pg_cnt <= pg_cnt + 1'b1;
                     pg_any <= 1'b1;
                  end
                  nacd_pkg::NACD_ST_RDOUT,
                  nacd_pkg::NACD_ST_HOLD: begin
                     state <= state;
                  end
                  default: state <= nacd_pkg::NACD_ST_HOLD;
               endcase
            end
            // each consumed prefetch asks for the following byte
            if (state == nacd_pkg::NACD_ST_RDOUT && sck_fall && out_cnt == 3'h0) begin
               RD_STB <= 1'b1;
               ARRAY_ADDR <= ARRAY_ADDR + 32'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------
   // array answers one cycle after the strobe
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rd_pend <= 1'b0;
         pf <= 8'h00;
      end else begin
         rd_pend <= RD_STB;
         if (rd_pend) begin
            pf <= RD_DATA;
         end
      end
   end

   assign out_next = (out_cnt == 3'h0) ? pf : out_sh;

   // shift on falling link edges so the host samples on rising ones
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         SO <= 1'b0;
         SO_OE_N <= 1'b1;
         out_sh <= 8'h00;
         out_cnt <= 3'h0;
      end else if (!cs_act || state != nacd_pkg::NACD_ST_RDOUT) begin
         SO_OE_N <= 1'b1;
         out_cnt <= 3'h0;
      end else if (sck_fall) begin
         SO <= out_next[7];
         SO_OE_N <= 1'b0;
         out_sh <= {out_next[6:0], 1'b0};
         out_cnt <= out_cnt + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // write enable and address length
   // ---------------------------------------------------------------
   // bare opcodes only count when the frame held exactly one byte
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         WRITE_EN_LATCH <= 1'b0;
         WIDE_ADDR <= nacd_pkg::WIDE_ADDR_RESET;
      end else begin
         if (PGM_COMMIT || ERASE_STB) begin
            WRITE_EN_LATCH <= 1'b0;
         end else if (cs_end && bare && cmd == WREN_OPCODE) begin
            WRITE_EN_LATCH <= 1'b1;
         end
         if (cs_end && bare && cmd == nacd_pkg::OP_ENTER_WIDE) begin
            WIDE_ADDR <= 1'b1;
         end else if (cs_end && bare && cmd == nacd_pkg::OP_EXIT_WIDE) begin
            WIDE_ADDR <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   sequence s_range_end;
      cs_end && cmd_ok && addr_done && cmd == nacd_pkg::OP_RANGE_CHECK;
   endsequence
   property p_range_check;
      s_range_end |=> CHECK_STB && CHECK_END_ADDR == $past(addr_sh[31:0])
         && ARRAY_ADDR == $past(addr_sh[63:32]);
   endproperty
   a_range_check: assert property (p_range_check) else $error("range check not issued");

   property p_plain_len;
      (byte_evt && state == nacd_pkg::NACD_ST_CMD && rx_byte == nacd_pkg::OP_PLAIN_READ_VAR)
         |=> need == (WIDE_ADDR ? 4'h4 : 4'h3);
   endproperty
   a_plain_len: assert property (p_plain_len) else $error("plain read length wrong");

   sequence s_mode_byte;
      byte_evt && state == nacd_pkg::NACD_ST_DUMMY;
   endsequence
   property p_fast_start;
      s_mode_byte |=> state == nacd_pkg::NACD_ST_RDOUT && RD_STB ##1 rd_pend;
   endproperty
   a_fast_start: assert property (p_fast_start) else $error("fast read did not start");

   property p_prog_needs_wel;
      PGM_STB |-> WRITE_EN_LATCH;
   endproperty
   a_prog_needs_wel: assert property (p_prog_needs_wel) else $error("program without enable");

   property p_commit_clears;
      PGM_COMMIT |=> !WRITE_EN_LATCH && !PGM_COMMIT;
   endproperty
   a_commit_clears: assert property (p_commit_clears) else $error("enable kept after commit");

   property p_small_erase;
      (cs_end && cmd_ok && addr_done && (cmd == nacd_pkg::OP_SMALL_ERASE_VAR
         || cmd == nacd_pkg::OP_SMALL_ERASE_4B)) |=> ERASE_STB && !ERASE_LARGE ##1 !WRITE_EN_LATCH;
   endproperty
   a_small_erase: assert property (p_small_erase) else $error("small erase wrong");

   property p_erase_needs_wel;
      ERASE_STB |-> WRITE_EN_LATCH;
   endproperty
   a_erase_needs_wel: assert property (p_erase_needs_wel) else $error("erase without enable");

   property p_large_erase;
      (cs_end && cmd_ok && addr_done && cmd == nacd_pkg::OP_LARGE_ERASE_VAR)
         |=> ERASE_STB && ERASE_LARGE;
   endproperty
   a_large_erase: assert property (p_large_erase) else $error("large erase wrong");

   property p_wide_mode;
      (cs_end && bare && cmd == nacd_pkg::OP_ENTER_WIDE) |=> WIDE_ADDR [*2];
   endproperty
   a_wide_mode: assert property (p_wide_mode) else $error("wide mode not entered");

   property p_stream;
      (cs_act && state == nacd_pkg::NACD_ST_RDOUT && sck_fall && out_cnt == 3'h0)
         |=> RD_STB && ARRAY_ADDR == $past(ARRAY_ADDR) + 32'h1;
   endproperty
   a_stream: assert property (p_stream) else $error("read address did not step");

endmodule // nacd_cmd_decode

// ==== core/nacd_link_sync.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// link pin synchroniser and edge finder
// ------------------------------------------------------------------
module nacd_link_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic sck_rise,
   output logic sck_fall,
   output logic cs_act,
   output logic cs_end,
   output logic si_s
);

   logic [2:0] meta;
   logic [2:0] sync;
   logic [2:0] hist;

   // two stages per pin, third only for edge finding
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 3'h2;
         sync <= 3'h2;
         hist <= 3'h2;
      end else begin
         meta <= {si, cs_n, sck};
         sync <= meta;
         hist <= sync;
      end
   end

   // registered events, all aligned to the same stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_rise <= 1'b0;
         sck_fall <= 1'b0;
         cs_act <= 1'b0;
         cs_end <= 1'b0;
         si_s <= 1'b0;
      end else begin
         sck_rise <= sync[0] & ~hist[0];
         sck_fall <= ~sync[0] & hist[0];
         cs_act <= ~sync[1];
         cs_end <= sync[1] & ~hist[1];
         si_s <= sync[2];
      end
   end

endmodule // nacd_link_sync

// ==== inc/nacd_pkg.sv ====
package nacd_pkg;

   // --------------------------------------------------------------
   // opcodes of the array transactions and of the address-length switches
   // --------------------------------------------------------------
   localparam logic [7:0] OP_RANGE_CHECK = 8'h5b;
   localparam logic [7:0] OP_PLAIN_READ_VAR = 8'h03;
   localparam logic [7:0] OP_PLAIN_READ_4B = 8'h13;
   localparam logic [7:0] OP_FAST_READ_VAR = 8'h0b;
   localparam logic [7:0] OP_FAST_READ_4B = 8'h0c;
   localparam logic [7:0] OP_PROGRAM_VAR = 8'h02;
   localparam logic [7:0] OP_PROGRAM_4B = 8'h12;
   localparam logic [7:0] OP_SMALL_ERASE_VAR = 8'h20;
   localparam logic [7:0] OP_SMALL_ERASE_4B = 8'h21;
   localparam logic [7:0] OP_LARGE_ERASE_VAR = 8'hd8;
   localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
   localparam logic [7:0] OP_EXIT_WIDE = 8'hb8;

   // --------------------------------------------------------------
   // byte counts, limits and reset values
   // --------------------------------------------------------------
   localparam logic [3:0] NARROW_ADDR_BYTES = 4'h3;
   localparam logic [3:0] WIDE_ADDR_BYTES = 4'h4;
   localparam logic [3:0] RANGE_ADDR_BYTES = 4'h8;
   localparam int PLAIN_READ_MAX_MHZ = 50;
   localparam int FAST_READ_MAX_MHZ = 166;
   localparam int PAGE_BYTES_DEFAULT = 256;
   localparam logic WIDE_ADDR_RESET = 1'b0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // --------------------------------------------------------------
   // frame sequencer states, gray along cmd-addr-dummy-read
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      NACD_ST_CMD = 3'b000,
      NACD_ST_ADDR = 3'b001,
      NACD_ST_DUMMY = 3'b011,
      NACD_ST_RDOUT = 3'b010,
      NACD_ST_PGIN = 3'b101,
      NACD_ST_HOLD = 3'b100
   } nacd_state_t;

endpackage

// ==== tb/nacd_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the serial link: mode 0, single line, msb first
// ----------------------------------------------------------------
module nacd_host_model (
   input wire logic core_clk,
   input wire logic so,
   input wire logic so_oe_n,
   output logic sck,
   output logic cs_n,
   output logic si
);
   // 2.5 MHz link clock, far below both read ceilings
   localparam int HALF_NS = 200;

   // idle: clock low, deselected
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // one framed transfer; read bits taken late in the high phase,
   // since the answer lags each falling edge by a few core cycles
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      @(posedge core_clk);
      #13;
      cs_n = 1'b0;
      foreach (tx[k]) begin
         for (int i = 7; i >= 0; i--) begin
            si = tx[k][i];
            #HALF_NS;
            sck = 1'b1;
            #(HALF_NS - 10);
            b[i] = so_oe_n ? 1'bx : so; // undriven line never passes as data
            #10;
            sck = 1'b0;
         end
         rx.push_back(b);
      end
      #HALF_NS;
      cs_n = 1'b1;
      si = ~si; // released line must not keep showing the last bit
      #(2 * HALF_NS);
   endtask
endmodule // nacd_host_model

// ==== tb/test_nor_array_command_decode.sv ====
`timescale 1ns/1ps
module test_nor_array_command_decode;
   localparam logic [7:0] WREN_OP = 8'h06; // write enable opcode given to the decoder
   logic core_clk, resetn, sck, cs_n, si, so, so_oe_n;
   logic rd_stb, pgm_stb, pgm_commit, erase_stb, erase_large, check_stb, wide_addr, wel;
   logic er_large;
   logic [7:0] rd_data, pgm_data;
   logic [31:0] array_addr, check_end_addr, er_addr, ck_s, ck_e;
   logic [39:0] pg_q[$];
   logic [7:0] rx[$];
   int n_fail, cmp_count, n_erase, n_check, n_commit;

   nacd_cmd_decode #(.PAGE_BYTES(nacd_pkg::PAGE_BYTES_DEFAULT), .WREN_OPCODE(WREN_OP))
   nacd_cmd_decode_inst (.CORE_CLK(core_clk), .RESETN(resetn), .SCK(sck), .CS_N(cs_n),
      .SI(si), .SO(so), .SO_OE_N(so_oe_n), .ARRAY_ADDR(array_addr), .RD_STB(rd_stb),
      .RD_DATA(rd_data), .PGM_STB(pgm_stb), .PGM_DATA(pgm_data), .PGM_COMMIT(pgm_commit),
      .ERASE_STB(erase_stb), .ERASE_LARGE(erase_large), .CHECK_STB(check_stb),
      .CHECK_END_ADDR(check_end_addr), .WIDE_ADDR(wide_addr), .WRITE_EN_LATCH(wel));

   nacd_host_model nacd_host_model_inst (.core_clk(core_clk), .so(so), .so_oe_n(so_oe_n),
      .sck(sck), .cs_n(cs_n), .si(si));

   // ----------------------------------------------------------------
   // clock and array stand-in
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // array answers one cycle after the request; strobes logged for later compare
   always @(posedge core_clk) begin
      if (rd_stb === 1'b1) rd_data <= array_addr[7:0] ^ 8'h5a;
      if (erase_stb === 1'b1) begin
         n_erase <= n_erase + 1;
         er_addr <= array_addr;
         er_large <= erase_large;
      end
      if (check_stb === 1'b1) begin
         n_check <= n_check + 1;
         ck_s <= array_addr;
         ck_e <= check_end_addr;
      end
      if (pgm_stb === 1'b1) pg_q.push_back({array_addr, pgm_data});
      if (pgm_commit === 1'b1) n_commit <= n_commit + 1;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic results;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bounded wait for a logged strobe; running out ends the run
   task automatic await(ref int cnt, input int was);
      for (int k = 0; k < 40; k++) begin
         if (cnt != was) return;
         @(posedge core_clk);
      end
      n_fail++;
      $display("unexpected strobe count expected %0d seen %0d", was + 1, cnt);
      results();
   endtask

   task automatic cmd(input logic [7:0] b[$]);
      nacd_host_model_inst.frame(b, rx);
   endtask

   task automatic wren;
      cmd({WREN_OP});
      chk("write enable latch", 40'h1, wel);
   endtask

   // header, then n clocked bytes compared with the array pattern
   task automatic read_check(input logic [7:0] hdr[$], input logic [31:0] a, input int n);
      logic [7:0] tx[$];
      tx = hdr;
      repeat (n) tx.push_back(8'h00);
      nacd_host_model_inst.frame(tx, rx);
      for (int k = 0; k < n; k++) begin
         chk("read byte", {32'h0, (a[7:0] + k[7:0]) ^ 8'h5a}, {32'h0, rx[hdr.size() + k]});
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk("output enable", 40'h1, so_oe_n);
      chk("wide address", 40'h0, wide_addr);
      chk("write enable latch", 40'h0, wel);
   endtask

   // erase without enable is ignored, then a narrow erase goes through
   task automatic t_erase_narrow;
      int was;
      was = n_erase;
      cmd({8'h20, 8'h12, 8'h34, 8'h56});
      repeat (20) @(posedge core_clk);
      chk("refused erase count", was, n_erase);
      wren();
      cmd({8'h20, 8'h12, 8'h34, 8'h56});
      await(n_erase, was);
      chk("erase address", 40'h0000123456, er_addr);
      chk("erase size", 40'h0, er_large);
      chk("latch after erase", 40'h0, wel);
   endtask

   task automatic t_wide_erase;
      int was;
      cmd({8'hb7});
      chk("wide address", 40'h1, wide_addr);
      wren();
      was = n_erase;
      cmd({8'hd8, 8'h00, 8'h04, 8'h00, 8'h00});
      await(n_erase, was);
      chk("large erase address", 40'h0000040000, er_addr);
      chk("large erase size", 40'h1, er_large);
      wren();
      was = n_erase;
      cmd({8'h21, 8'h01, 8'h02, 8'h30, 8'h00});
      await(n_erase, was);
      chk("small erase address", 40'h0001023000, er_addr);
      chk("small erase size", 40'h0, er_large);
   endtask

   // program crossing the page end wraps to the page start
   task automatic t_program;
      int was;
      wren();
      pg_q.delete();
      was = n_commit;
      cmd({8'h02, 8'h00, 8'h00, 8'h01, 8'hfe, 8'ha1, 8'hb2, 8'hc3});
      await(n_commit, was);
      chk("program count", 40'h3, pg_q.size());
      chk("program byte 0", {32'h1fe, 8'ha1}, pg_q[0]);
      chk("program byte 1", {32'h1ff, 8'hb2}, pg_q[1]);
      chk("program byte 2", {32'h100, 8'hc3}, pg_q[2]);
      chk("latch after program", 40'h0, wel);
      cmd({8'hb8});
      chk("wide address", 40'h0, wide_addr);
      was = n_commit;
      cmd({8'h12, 8'h00, 8'h00, 8'h20, 8'h00, 8'hd4});
      repeat (20) @(posedge core_clk);
      chk("refused commit count", was, n_commit);
      wren();
      pg_q.delete();
      cmd({8'h12, 8'h00, 8'h00, 8'h20, 8'h00, 8'hd4});
      await(n_commit, was);
      chk("four byte program", {32'h2000, 8'hd4}, pg_q[0]);
   endtask

   // all four read forms in narrow mode, streaming across a byte carry
   task automatic t_reads;
      read_check({8'h03, 8'h00, 8'h00, 8'hfe}, 32'h000000fe, 3);
      read_check({8'h13, 8'h01, 8'h02, 8'h03, 8'h04}, 32'h01020304, 2);
      read_check({8'h0b, 8'h00, 8'h10, 8'h20, 8'h00}, 32'h00001020, 2);
      read_check({8'h0c, 8'h00, 8'h00, 8'h00, 8'h40, 8'ha5}, 32'h00000040, 2);
   endtask

   // range check needs no enable and leaves a set latch alone
   task automatic t_check;
      int was;
      wren();
      was = n_check;
      cmd({8'h5b, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h1f, 8'hff});
      await(n_check, was);
      chk("check start", 40'h0000001000, ck_s);
      chk("check end", 40'h0000001fff, ck_e);
      chk("latch after check", 40'h1, wel);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn <= 1'b0;
      rd_data <= 8'h00;
      repeat (3) @(posedge core_clk);
      t_reset();
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_erase_narrow();
      t_wide_erase();
      t_program();
      t_reads();
      t_check();
      results();
   end
endmodule // test_nor_array_command_decode
